// ==== design/btf_pkg.sv ====
/*
  Constants, register map and carrier types of the block-transfer scan and
  fault logger. Assumes a single 40 MHz clock, a synchronous active-low reset
  and a processor-side register port with read data one cycle after the strobe.
*/
// Overview of operation
// - Buffer holds at most 72 words, four modules.
// - Oversized block waits until the buffer has room.
// - Each enabled transfer ends with done or error.
// - File length above 64 words is an error.
// - Unmatched rack, group, module location is an error.
// - Location or length errors set both error flags.
// - Communication fault retried once; error after second.
// - After error, module refused until control word cleared.
// - Fault bitmap, one bit per quarter rack.
// - Quarter rack is four module slots, 32 points.
// - One bitmap word covers four racks.
// - Per quarter rack counter of transmission retries.
// - Four consecutive counter words per rack.
// - Write data rides with write exchange, read with read.
package btf_pkg;
  localparam int DW = 16;
  localparam int AW = 6;
  localparam int SLOTS = 4;
  localparam int RACKS = 4;
  localparam int QUARTERS = 16;
  localparam int BUF_WORDS = 72;
  localparam int MAX_MODULES = 4;
  localparam int MAX_LEN = 64;

  // Register word addresses.
  localparam logic [AW-1:0] CTRL_BASE = 6'h00;
  localparam logic [AW-1:0] TSTAT_ADDR = 6'h04;
  localparam logic [AW-1:0] FAULT_ADDR = 6'h05;
  localparam logic [AW-1:0] BUSED_ADDR = 6'h06;
  localparam logic [AW-1:0] ISTAT_ADDR = 6'h07;
  localparam logic [AW-1:0] IMASK_ADDR = 6'h08;
  localparam logic [AW-1:0] INST_BASE = 6'h0c;
  localparam logic [AW-1:0] RETRY_BASE = 6'h10;

  // Control word fields.
  localparam int CTRL_LEN_LSB = 0;
  localparam int CTRL_LEN_W = 7;
  localparam int CTRL_MOD_BIT = 7;
  localparam int CTRL_GRP_LSB = 8;
  localparam int CTRL_RACK_LSB = 11;
  localparam int CTRL_WR_BIT = 13;
  localparam int CTRL_EN_BIT = 14;

  // Transfer status fields.
  localparam int TSTAT_DONE_LSB = 0;
  localparam int TSTAT_RERR_LSB = 4;
  localparam int TSTAT_WERR_LSB = 8;
  localparam int TSTAT_BUSY_LSB = 12;

  // Interrupt status bits.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_W = 3;

  // Reset values.
  localparam logic [DW-1:0] CTRL_RST = 16'h0000;
  localparam logic [DW-1:0] INST_RST = 16'h0000;
  localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;

  typedef enum {BTF_LNK_IDLE, BTF_LNK_WAIT, BTF_LNK_RESEND} btf_link_st_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] quarter;
    logic [1:0] slot;
    logic [6:0] len;
  } btf_link_req_t;

  typedef struct packed {
    logic [DW-1:0] ctrl;
    logic pend;
    logic acc;
    logic done;
    logic rerr;
    logic werr;
  } btf_slot_t;
endpackage : btf_pkg

// ==== design/btf_scan_logger.sv ====
/*
  Block-transfer scan and fault logger: admits up to four transfer requests
  into a 72-word scanner buffer, runs them one at a time over the adapter
  link with one retry on fault, and logs faults and retries per quarter rack.
  Assumes the adapter answers each link request with exactly one pulse on
  link_done_i or link_fault_i, some cycles after the request pulse.
*/
// The implementer's own choices: strobed register access and the register offsets.
module btf_scan_logger
  import btf_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DW-1:0] rdata_o,
  output logic irq_o,
  output btf_link_req_t link_req_o,
  input wire logic link_done_i,
  input wire logic link_fault_i
);

  typedef struct packed {
    btf_slot_t [SLOTS-1:0] slot;
    logic [7:0] used;
    logic [2:0] nacc;
    btf_link_st_t lst;
    logic [1:0] cur;
    logic second;
    btf_link_req_t req;
    logic [QUARTERS-1:0] fault;
    logic [QUARTERS-1:0][DW-1:0] retry;
    logic [RACKS-1:0][DW-1:0] inst;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imask;
    logic irq;
    logic [DW-1:0] rdata;
  } btf_state_t;

  btf_state_t s;
  btf_state_t next_s;

  // Observation points for the checks below.
  logic acc_fire;
  logic [7:0] acc_len;
  logic bad_len;
  logic bad_loc;

  // Quarter rack of a control word: four slots, two groups of two modules.
  function automatic logic [3:0] quarter_of(input logic [DW-1:0] c);
    quarter_of = {c[CTRL_RACK_LSB +: 2], c[CTRL_GRP_LSB + 1 +: 2]};
  endfunction : quarter_of

  function automatic logic [6:0] len_of(input logic [DW-1:0] c);
    len_of = c[CTRL_LEN_LSB +: CTRL_LEN_W];
  endfunction : len_of

  // Next-state logic: register port, admission, link sequencing, logging.
  always_comb
  begin
    logic [1:0] idx;
    logic [3:0] q;
    logic [3:0] loc;
    logic found;
    logic ev_done;
    logic ev_err;
    logic ev_fault;
    idx = addr_i[1:0];
    q = 4'h0;
    loc = 4'h0;
    found = 1'b0;
    ev_done = 1'b0;
    ev_err = 1'b0;
    ev_fault = 1'b0;
    next_s = s;
    next_s.req.valid = 1'b0;
    acc_fire = 1'b0;
    acc_len = 8'h00;
    bad_len = 1'b0;
    bad_loc = 1'b0;

    // Register writes. A control word with an error latched is refused
    // unless the write is all zero, which clears it.
    if (wr_i)
    begin
      if (addr_i[AW-1:2] == CTRL_BASE[AW-1:2])
      begin
        if (wdata_i == CTRL_RST)
        begin
          if (!s.slot[idx].acc)
          begin
            next_s.slot[idx] = '0;
          end
        end
        else if (!s.slot[idx].acc && !s.slot[idx].rerr && !s.slot[idx].werr)
        begin
          loc = {wdata_i[CTRL_GRP_LSB +: 3], wdata_i[CTRL_MOD_BIT]};
          next_s.slot[idx].ctrl = wdata_i;
          next_s.slot[idx].done = 1'b0;
          next_s.slot[idx].pend = 1'b0;
          if (wdata_i[CTRL_EN_BIT])
          begin
            bad_len = (len_of(wdata_i) > 7'(MAX_LEN));
            bad_loc = !s.inst[wdata_i[CTRL_RACK_LSB +: 2]][loc];
            if (bad_len || bad_loc)
            begin
              next_s.slot[idx].rerr = 1'b1;
              next_s.slot[idx].werr = 1'b1;
              ev_err = 1'b1;
            end
            else
            begin
              next_s.slot[idx].pend = 1'b1;
            end
          end
        end
      end
      else if (addr_i == IMASK_ADDR)
      begin
        next_s.imask = wdata_i[IRQ_W-1:0];
      end
      else if (addr_i[AW-1:2] == INST_BASE[AW-1:2])
      begin
        next_s.inst[idx] = wdata_i;
      end
    end

    // Register reads; data stand one cycle later. Interrupt status clears
    // on read, but events of this same cycle are merged in afterwards.
    next_s.rdata = '0;
    if (rd_i)
    begin
      if (addr_i[AW-1:2] == CTRL_BASE[AW-1:2])
      begin
        next_s.rdata = s.slot[idx].ctrl;
      end
      else if (addr_i == TSTAT_ADDR)
      begin
        for (int i = 0; i < SLOTS; i++)
        begin
          next_s.rdata[TSTAT_DONE_LSB + i] = s.slot[i].done;
          next_s.rdata[TSTAT_RERR_LSB + i] = s.slot[i].rerr;
          next_s.rdata[TSTAT_WERR_LSB + i] = s.slot[i].werr;
          next_s.rdata[TSTAT_BUSY_LSB + i] = s.slot[i].pend | s.slot[i].acc;
        end
      end
      else if (addr_i == FAULT_ADDR)
      begin
        next_s.rdata = s.fault;
      end
      else if (addr_i == BUSED_ADDR)
      begin
        next_s.rdata = {8'h00, s.used};
      end
      else if (addr_i == ISTAT_ADDR)
      begin
        next_s.rdata = {13'h0000, s.istat};
        next_s.istat = '0;
      end
      else if (addr_i == IMASK_ADDR)
      begin
        next_s.rdata = {13'h0000, s.imask};
      end
      else if (addr_i[AW-1:2] == INST_BASE[AW-1:2])
      begin
        next_s.rdata = s.inst[idx];
      end
      else if (addr_i[AW-1:4] == RETRY_BASE[AW-1:4])
      begin
        next_s.rdata = s.retry[addr_i[3:0]];
      end
    end

    // Link sequencing: one transfer on the link at a time.
    q = quarter_of(s.slot[s.cur].ctrl);
    case (s.lst)
      BTF_LNK_IDLE:
      begin
        for (int i = 0; i < SLOTS; i++)
        begin
          if (!found && s.slot[i].acc)
          begin
            found = 1'b1;
            next_s.cur = 2'(i);
          end
        end
        if (found)
        begin
          next_s.second = 1'b0;
          next_s.lst = BTF_LNK_WAIT;
          next_s.req.valid = 1'b1;
          next_s.req.write = s.slot[next_s.cur].ctrl[CTRL_WR_BIT];
          next_s.req.quarter = quarter_of(s.slot[next_s.cur].ctrl);
          next_s.req.slot = next_s.cur;
          next_s.req.len = len_of(s.slot[next_s.cur].ctrl);
        end
      end
      BTF_LNK_WAIT:
      begin
        if (link_done_i)
        begin
          next_s.slot[s.cur].acc = 1'b0;
          next_s.slot[s.cur].pend = 1'b0;
          next_s.slot[s.cur].done = 1'b1;
          next_s.used = s.used - 8'(len_of(s.slot[s.cur].ctrl));
          next_s.nacc = s.nacc - 3'h1;
          next_s.lst = BTF_LNK_IDLE;
          ev_done = 1'b1;
        end
        else if (link_fault_i)
        begin
          ev_fault = 1'b1;
          next_s.fault[q] = 1'b1;
          next_s.retry[q] = s.retry[q] + 16'h0001;
          if (!s.second)
          begin
            next_s.lst = BTF_LNK_RESEND;
          end
          else
          begin
            next_s.slot[s.cur].acc = 1'b0;
            next_s.slot[s.cur].pend = 1'b0;
            if (s.slot[s.cur].ctrl[CTRL_WR_BIT])
            begin
              next_s.slot[s.cur].werr = 1'b1;
            end
            else
            begin
              next_s.slot[s.cur].rerr = 1'b1;
            end
            next_s.used = s.used - 8'(len_of(s.slot[s.cur].ctrl));
            next_s.nacc = s.nacc - 3'h1;
            next_s.lst = BTF_LNK_IDLE;
            ev_err = 1'b1;
          end
        end
      end
      BTF_LNK_RESEND:
      begin
        // The same request goes out once more; a second fault ends it.
        next_s.second = 1'b1;
        next_s.lst = BTF_LNK_WAIT;
        next_s.req.valid = 1'b1;
        next_s.req.write = s.slot[s.cur].ctrl[CTRL_WR_BIT];
        next_s.req.quarter = q;
        next_s.req.slot = s.cur;
        next_s.req.len = len_of(s.slot[s.cur].ctrl);
      end
      default:
      begin
        next_s.lst = BTF_LNK_IDLE;
      end
    endcase

    // Admission: the first pending block that fits whole is taken. A block
    // that does not fit stays pending; it is never split across scans.
    found = 1'b0;
    for (int i = 0; i < SLOTS; i++)
    begin
      if (!found && next_s.slot[i].pend && !next_s.slot[i].acc &&
          next_s.nacc < 3'(MAX_MODULES) &&
          (9'(next_s.used) + 9'(len_of(next_s.slot[i].ctrl))) <= 9'(BUF_WORDS))
      begin
        found = 1'b1;
        acc_fire = 1'b1;
        acc_len = 8'(len_of(next_s.slot[i].ctrl));
        next_s.slot[i].acc = 1'b1;
        next_s.used = next_s.used + 8'(len_of(next_s.slot[i].ctrl));
        next_s.nacc = next_s.nacc + 3'h1;
      end
    end

    // Sticky events win over the clear-on-read above.
    next_s.istat[IRQ_DONE] = next_s.istat[IRQ_DONE] | ev_done;
    next_s.istat[IRQ_ERR] = next_s.istat[IRQ_ERR] | ev_err;
    next_s.istat[IRQ_FAULT] = next_s.istat[IRQ_FAULT] | ev_fault;
    next_s.irq = |(next_s.istat & next_s.imask);
  end

  // State register with synchronous reset.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      s <= '0;
      s.lst <= BTF_LNK_IDLE;
      s.imask <= IMASK_RST;
      s.inst <= {RACKS{INST_RST}};
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state flops.
  assign rdata_o = s.rdata;
  assign irq_o = s.irq;
  assign link_req_o = s.req;

  // Checks.
  property p_buf_max;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (s.used <= 8'(BUF_WORDS)) && (s.nacc <= 3'(MAX_MODULES));
  endproperty
  a_buf_max: assert property (p_buf_max) else $error("buffer over 72 words or four modules");

  property p_defer;
    @(posedge mclk_i) disable iff (!rst_n_i)
    acc_fire |=> (s.used >= $past(acc_len)) && (s.used <= 8'(BUF_WORDS));
  endproperty
  a_defer: assert property (p_defer) else $error("block admitted without room");

  property p_one_end;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !(s.slot[0].done && (s.slot[0].rerr || s.slot[0].werr)) &&
    !(s.slot[1].done && (s.slot[1].rerr || s.slot[1].werr)) &&
    !(s.slot[2].done && (s.slot[2].rerr || s.slot[2].werr)) &&
    !(s.slot[3].done && (s.slot[3].rerr || s.slot[3].werr));
  endproperty
  a_one_end: assert property (p_one_end) else $error("done and error both set");

  property p_len_err;
    @(posedge mclk_i) disable iff (!rst_n_i)
    bad_len |=> s.slot[$past(addr_i[1:0])].rerr && s.slot[$past(addr_i[1:0])].werr &&
                !s.slot[$past(addr_i[1:0])].pend;
  endproperty
  a_len_err: assert property (p_len_err) else $error("long block not rejected");

  property p_loc_err;
    @(posedge mclk_i) disable iff (!rst_n_i)
    bad_loc |=> s.slot[$past(addr_i[1:0])].rerr && s.slot[$past(addr_i[1:0])].werr;
  endproperty
  a_loc_err: assert property (p_loc_err) else $error("bad location not rejected");

  property p_retry;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (s.lst == BTF_LNK_WAIT && !s.second && link_fault_i && !link_done_i)
      |=> ##1 (link_req_o.valid && link_req_o.slot == $past(s.cur, 2));
  endproperty
  a_retry: assert property (p_retry) else $error("faulted transfer not retried");

  property p_second_fault;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (s.lst == BTF_LNK_WAIT && s.second && link_fault_i && !link_done_i)
      |=> (s.slot[$past(s.cur)].rerr || s.slot[$past(s.cur)].werr) && s.lst == BTF_LNK_IDLE;
  endproperty
  a_second_fault: assert property (p_second_fault) else $error("no error after retry");

  property p_halt;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (s.slot[0].rerr && !(wr_i && addr_i == CTRL_BASE && wdata_i == CTRL_RST))
      |=> s.slot[0].rerr && !s.slot[0].pend && !s.slot[0].acc;
  endproperty
  a_halt: assert property (p_halt) else $error("errored module not halted");

  property p_fault_map;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (s.lst == BTF_LNK_WAIT && link_fault_i && !link_done_i)
      |=> s.fault[quarter_of(s.slot[$past(s.cur)].ctrl)];
  endproperty
  a_fault_map: assert property (p_fault_map) else $error("fault bit not set");

  // Quarter of the transfer on the link, for the retry counter check.
  logic [3:0] q_now;
  assign q_now = quarter_of(s.slot[s.cur].ctrl);

  property p_retry_cnt;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (s.lst == BTF_LNK_WAIT && link_fault_i && !link_done_i)
      |=> s.retry[$past(q_now)] == $past(s.retry[q_now]) + 16'h0001;
  endproperty
  a_retry_cnt: assert property (p_retry_cnt) else $error("retry count not advanced");

  property p_irq;
    @(posedge mclk_i) disable iff (!rst_n_i)
    irq_o == |(s.istat & s.imask);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output mismatch");

endmodule : btf_scan_logger

// ==== verif/btf_adapter_model.sv ====
/*
  Behavioural model of the remote chassis adapter at the far end of the link.
  Assumes one request pulse at a time and answers each with one done or one
  fault pulse after a programmable delay; faults are armed by the bench.
*/
module btf_adapter_model
  import btf_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input btf_link_req_t req_i,
  input wire logic load_i,
  input wire logic [1:0] faults_i,
  input wire logic [7:0] delay_i,
  output logic done_o,
  output logic fault_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy;
  logic [7:0] cnt;
  logic [1:0] left;

  // One answer per request; armed faults are spent first, so a retry sees the next one.
  always_ff @(posedge mclk_i)
  begin
    done_o <= 1'b0;
    fault_o <= 1'b0;
    if (!rst_n_i)
    begin
      busy <= 1'b0;
      cnt <= 8'h00;
      left <= 2'h0;
    end
    else
    begin
      if (load_i)
        left <= faults_i;
      if (req_i.valid)
      begin
        busy <= 1'b1;
        cnt <= delay_i;
      end
      else if (busy)
      begin
        if (cnt != 8'h00)
          cnt <= cnt - 8'h01;
        else
        begin
          busy <= 1'b0;
          if (left != 2'h0)
          begin
            fault_o <= 1'b1;
            left <= left - 2'h1;
          end
          else
            done_o <= 1'b1;
        end
      end
    end
  end
endmodule : btf_adapter_model

// ==== verif/test_btf_scan_logger.sv ====
/*
  Self-checking bench of the scan and fault logger: register reads and writes
  over the plain strobe port, with the adapter model on the link.
  Assumes a 40 MHz clock and read data in the cycle after the read strobe.
*/
module test_btf_scan_logger
  import btf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [AW-1:0] addr_i = '0;
  logic [DW-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DW-1:0] rdata_o;
  logic irq_o;
  btf_link_req_t link_req;
  btf_link_req_t last_req = '0;
  logic link_done;
  logic link_fault;
  logic load = 1'b0;
  logic [1:0] nfault = 2'h0;
  logic [7:0] delay = 8'h08;
  logic [DW-1:0] d;
  int mismatches = 0;
  int compares = 0;
  int req_count = 0;

  // Free-running bench clock.
  always #12.5 mclk_i = ~mclk_i;

  btf_scan_logger i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .link_req_o(link_req), .link_done_i(link_done), .link_fault_i(link_fault));

  btf_adapter_model i_adapter (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(link_req),
    .load_i(load), .faults_i(nfault), .delay_i(delay), .done_o(link_done),
    .fault_o(link_fault));

  // Capture every link request so retries can be counted.
  always @(posedge mclk_i)
  begin
    if (link_req.valid === 1'b1)
    begin
      last_req <= link_req;
      req_count <= req_count + 1;
    end
  end

  task automatic close_out();
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd

  task automatic rchk(input string what, input logic [AW-1:0] a, input logic [DW-1:0] exp);
    logic [DW-1:0] v;
    rd(a, v);
    check(what, v, exp);
  endtask : rchk

  // Polls the transfer status; the bound keeps a lost answer from hanging the run.
  task automatic wait_bits(input logic [DW-1:0] bits);
    logic [DW-1:0] v;
    v = '0;
    for (int i = 0; i < 200 && (v & bits) !== bits; i++)
      rd(TSTAT_ADDR, v);
    check("status bits", v & bits, bits);
  endtask : wait_bits

  task automatic arm(input logic [1:0] n);
    @(posedge mclk_i);
    load <= 1'b1;
    nfault <= n;
    @(posedge mclk_i);
    load <= 1'b0;
  endtask : arm

  // Watchdog sized well above the expected few hundred cycles.
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    close_out();
  end

  initial
  begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rchk("tstat reset", TSTAT_ADDR, 16'h0000);
    rchk("fault reset", FAULT_ADDR, 16'h0000);
    rchk("used reset", BUSED_ADDR, 16'h0000);
    rchk("istat reset", ISTAT_ADDR, 16'h0000);
    rchk("imask reset", IMASK_ADDR, 16'h0000);
    rchk("retry reset", RETRY_BASE, 16'h0000);
    wr(6'h09, 16'hffff);
    rchk("unmapped", 6'h09, 16'h0000);
    wr(FAULT_ADDR, 16'hffff);
    rchk("fault read only", FAULT_ADDR, 16'h0000);
    wr(INST_BASE, 16'h00ff);
    rchk("install map", INST_BASE, 16'h00ff);
    wr(IMASK_ADDR, 16'h0007);
    rchk("imask", IMASK_ADDR, 16'h0007);
    // Plain read transfer, rack 0 group 1 module 0, five words.
    wr(CTRL_BASE, 16'h4105);
    rchk("used one", BUSED_ADDR, 16'h0005);
    wait_bits(16'h0001);
    check("request", {2'h0, last_req.write, last_req.quarter, last_req.slot, last_req.len},
      16'h0005);
    check("irq done", {15'h0, irq_o}, 16'h0001);
    rchk("istat done", ISTAT_ADDR, 16'h0001);
    @(posedge mclk_i);
    #1 check("irq cleared", {15'h0, irq_o}, 16'h0000);
    rchk("used freed", BUSED_ADDR, 16'h0000);
    // Length above 64 and a missing module both raise both error flags.
    wr(CTRL_BASE + 6'h01, 16'h4041);
    rchk("len error", TSTAT_ADDR, 16'h0221);
    wr(CTRL_BASE + 6'h02, 16'h4803);
    rchk("loc error", TSTAT_ADDR, 16'h0661);
    check("no link traffic", 16'(req_count), 16'h0001);
    rchk("istat error", ISTAT_ADDR, 16'h0002);
    // A latched error refuses new requests until the word is cleared.
    wr(CTRL_BASE + 6'h01, 16'h4108);
    rchk("halted", TSTAT_ADDR, 16'h0661);
    rchk("halted used", BUSED_ADDR, 16'h0000);
    wr(CTRL_BASE + 6'h01, 16'h0000);
    wr(CTRL_BASE + 6'h02, 16'h0000);
    rchk("released", TSTAT_ADDR, 16'h0001);
    // A word without the enable bit is only stored; it starts nothing.
    wr(CTRL_BASE + 6'h03, 16'h2204);
    rchk("ctrl stored", CTRL_BASE + 6'h03, 16'h2204);
    rchk("idle stored", TSTAT_ADDR, 16'h0001);
    // One fault then success: write transfer to group 2, second quarter.
    arm(2'h1);
    wr(CTRL_BASE + 6'h03, 16'h6204);
    wait_bits(16'h0008);
    check("one retry", 16'(req_count), 16'h0003);
    d = {2'h0, last_req.write, last_req.quarter, last_req.slot, last_req.len};
    check("write request", d, 16'h2384);
    rchk("retry q1", RETRY_BASE + 6'h01, 16'h0001);
    rchk("bitmap q1", FAULT_ADDR, 16'h0002);
    rchk("istat fault", ISTAT_ADDR, 16'h0005);
    // Two faults end in a read error only.
    arm(2'h2);
    wr(CTRL_BASE, 16'h4105);
    wait_bits(16'h0010);
    rd(TSTAT_ADDR, d);
    check("read error only", d & 16'h0110, 16'h0010);
    check("two tries", 16'(req_count), 16'h0005);
    rchk("retry q0", RETRY_BASE, 16'h0002);
    rchk("bitmap q0", FAULT_ADDR, 16'h0003);
    // Fill the buffer to 72 words so the third block must wait.
    wr(CTRL_BASE, 16'h0000);
    wr(IMASK_ADDR, 16'h0000);
    rd(ISTAT_ADDR, d);
    delay <= 8'd40;
    wr(CTRL_BASE, 16'h4140);
    wr(CTRL_BASE + 6'h01, 16'h4108);
    wr(CTRL_BASE + 6'h02, 16'h4101);
    rchk("buffer full", BUSED_ADDR, 16'h0048);
    wait_bits(16'h0007);
    rchk("buffer empty", BUSED_ADDR, 16'h0000);
    check("irq masked", {15'h0, irq_o}, 16'h0000);
    wr(IMASK_ADDR, 16'h0001);
    repeat (2) @(posedge mclk_i);
    #1 check("irq unmasked", {15'h0, irq_o}, 16'h0001);
    close_out();
  end
endmodule : test_btf_scan_logger
